// ===== rtl/acso_pkg.sv
// shared constants and types for the axle count section occupancy block
package acso_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  // shortest head pulse that still looks like a wheel flange
  localparam int unsigned FLANGE_MIN_US = 100;
  localparam int unsigned FLANGE_MIN_CYC = (FLANGE_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  // time the busy relays keep their restoring contacts closed
  localparam int unsigned BUSY_HOLD_MS = 5;
  localparam int unsigned BUSY_HOLD_CYC = BUSY_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned COUNT_W = 8;

  localparam int unsigned BUS_AW = 8;
  localparam int unsigned BUS_DW = 16;
  localparam logic [BUS_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [BUS_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [BUS_AW-1:0] REG_COUNT = 8'h08;

  localparam int unsigned CTRL_ENTRY_BA = 0;
  localparam int unsigned CTRL_EXIT_BA = 1;
  localparam int unsigned CTRL_FAULT_CLR = 2;
  localparam int unsigned CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h1;

  localparam int unsigned STAT_OCC = 0;
  localparam int unsigned STAT_FAULT = 1;
  localparam int unsigned STAT_CLEAR_LINE = 2;
  localparam int unsigned STAT_VACANCY = 3;
  localparam int unsigned STAT_ANTIVALENT = 4;
  localparam int unsigned STAT_SUMMING = 5;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_B1 = 3'h1,
    SEQ_B2 = 3'h2,
    SEQ_B3 = 3'h3,
    SEQ_A1 = 3'h4,
    SEQ_A2 = 3'h5,
    SEQ_A3 = 3'h6
  } acso_seq_e;

  typedef enum logic {
    OCC_CLEAR = 1'b0,
    OCC_BUSY = 1'b1
  } acso_occ_e;

endpackage : acso_pkg

// ===== rtl/acso_axle_seq.sv
// one double wheel sensor: flange pulse filter and head order decoder
`timescale 1ns/1ps
module acso_axle_seq
  import acso_pkg::*;
#(
  parameter int unsigned FLT_CYC = FLANGE_MIN_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic head_a,
  input wire logic head_b,
  output logic axle_ba,
  output logic axle_ab
);

  localparam int unsigned FW = $clog2(FLT_CYC + 1);
  localparam logic [FW-1:0] FLT_LAST = FW'(FLT_CYC - 1);

  typedef struct packed {
    logic [1:0][FW-1:0] flt;
    logic [1:0] lvl;
    acso_seq_e st;
    logic ev_ba;
    logic ev_ab;
  } acso_seq_s;

  acso_seq_s s_q;
  acso_seq_s s_d;
  logic [1:0] raw;
  logic fa;
  logic fb;

  assign raw = {head_b, head_a};
  assign fa = s_q.lvl[0];
  assign fb = s_q.lvl[1];

  always_comb begin
    s_d = s_q;
    s_d.ev_ba = 1'b0;
    s_d.ev_ab = 1'b0;
    // a level moves only after the raw head held its new value long enough
    for (int i = 0; i < 2; i++) begin
      if (raw[i] == s_q.lvl[i]) begin
        s_d.flt[i] = '0;
      end else if (s_q.flt[i] == FLT_LAST) begin
        s_d.flt[i] = '0;
        s_d.lvl[i] = raw[i];
      end else begin
        s_d.flt[i] = s_q.flt[i] + FW'(1);
      end
    end
    // rocking back over the heads moves one step back, never counts
    unique case (s_q.st)
      SEQ_IDLE: begin
        if (fb && !fa) s_d.st = SEQ_B1;
        else if (fa && !fb) s_d.st = SEQ_A1;
      end
      SEQ_B1: begin
        if (fa && fb) s_d.st = SEQ_B2;
        else if (!fb) s_d.st = SEQ_IDLE;
      end
      SEQ_B2: begin
        if (fa && !fb) s_d.st = SEQ_B3;
        else if (!fa && fb) s_d.st = SEQ_B1;
        else if (!fa) s_d.st = SEQ_IDLE;
      end
      SEQ_B3: begin
        if (!fa && !fb) begin
          s_d.st = SEQ_IDLE;
          s_d.ev_ba = 1'b1;
        end else if (fb) begin
          s_d.st = SEQ_B2;
        end
      end
      SEQ_A1: begin
        if (fa && fb) s_d.st = SEQ_A2;
        else if (!fa) s_d.st = SEQ_IDLE;
      end
      SEQ_A2: begin
        if (fb && !fa) s_d.st = SEQ_A3;
        else if (!fb && fa) s_d.st = SEQ_A1;
        else if (!fb) s_d.st = SEQ_IDLE;
      end
      SEQ_A3: begin
        if (!fa && !fb) begin
          s_d.st = SEQ_IDLE;
          s_d.ev_ab = 1'b1;
        end else if (fa) begin
          s_d.st = SEQ_A2;
        end
      end
      default: s_d.st = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{flt: '0, lvl: 2'h0, st: SEQ_IDLE, ev_ba: 1'b0, ev_ab: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign axle_ba = s_q.ev_ba;
  assign axle_ab = s_q.ev_ab;

  chk_seq_order: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.ev_ba |-> $past(s_q.st) == SEQ_B3 && !fa && !fb)
    else $error("axle counted without full head order");
  chk_flange_filter: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(s_q.lvl[0]) |-> $past(s_q.flt[0]) == FLT_LAST)
    else $error("head level moved before the flange time");

endmodule : acso_axle_seq

// ===== rtl/acso_section.sv
// axle counting section: counter, occupancy state and clear relay chain
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// - axle passes only on b, ab, a, none or a, ab, b, none
// - discard head pulses shorter than a flange
// - amplifier release outputs drop after first axle
// - either head relay alone drops vacancy relay
// - dropped vacancy relay opens the clear line
// - released head relays energize antivalent relay
// - first axle: busy outputs on, vacant off
// - vacant outputs feed vacancy; busy outputs drive relays
// - busy relays release summing relay, opening line
// - count up on entry, down on exit
// - simultaneous count in and out both applied
// - no restore while axles remain inside
// - zero count restores clear outputs at once unless a count fault is pending
// - restore re-feeds vacancy relay, busy relays drop
// - antivalent relay drops once its feeds open
// - busy hold window lets vacancy self-latch
// - line closes only when all relays restored
// - head order per sensor configures counting direction
// - count out to zero restores standby
// - shared sensor counts one out, other in
module acso_section
  import acso_pkg::*;
#(
  parameter int unsigned CNT_W = COUNT_W,
  parameter int unsigned FLT_CYC = FLANGE_MIN_CYC,
  parameter int unsigned HOLD_CYC = BUSY_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic entry_head_a,
  input wire logic entry_head_b,
  input wire logic exit_head_a,
  input wire logic exit_head_b,
  input wire logic [BUS_AW-1:0] reg_addr,
  input wire logic [BUS_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [BUS_DW-1:0] reg_rdata,
  output logic amplifier_release_out_a,
  output logic amplifier_release_out_b,
  output logic head_release_relay_a,
  output logic head_release_relay_b,
  output logic busy_out_a,
  output logic busy_out_b,
  output logic vacant_out_a,
  output logic vacant_out_b,
  output logic vacancy_relay,
  output logic antivalent_relay,
  output logic busy_relay_a,
  output logic busy_relay_b,
  output logic busy_summing_relay,
  output logic clear_line,
  output logic [CNT_W-1:0] axle_count,
  output logic count_fault
);

  localparam int unsigned HW = $clog2(HOLD_CYC + 1);
  localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_CYC);
  localparam logic [CNT_W:0] CNT_MAX = {1'b0, {CNT_W{1'b1}}};

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [BUS_DW-1:0] rdata;
    acso_occ_e occ;
    logic [CNT_W-1:0] cnt;
    logic fault;
    logic amp_a;
    logic amp_b;
    logic hrel_a;
    logic hrel_b;
    logic busy_a;
    logic busy_b;
    logic vac_a;
    logic vac_b;
    logic vacancy;
    logic antival;
    logic brel_a;
    logic brel_b;
    logic summing;
    logic [HW-1:0] hold;
    logic line;
  } acso_sec_s;

  acso_sec_s s_q;
  acso_sec_s s_d;
  logic ent_ba;
  logic ent_ab;
  logic ext_ba;
  logic ext_ab;
  logic in_ent;
  logic out_ent;
  logic in_ext;
  logic out_ext;
  logic any_evt;
  logic [CNT_W:0] n_in;
  logic [CNT_W:0] n_out;
  logic [CNT_W:0] sum_v;
  logic [CNT_W:0] res_v;
  logic err_set;
  logic agree;

  ////////////////////////////////////////////////////////////////////////////
  // sensors

  acso_axle_seq #(.FLT_CYC(FLT_CYC)) u_entry (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .head_a(entry_head_a),
    .head_b(entry_head_b),
    .axle_ba(ent_ba),
    .axle_ab(ent_ab)
  );

  acso_axle_seq #(.FLT_CYC(FLT_CYC)) u_exit (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .head_a(exit_head_a),
    .head_b(exit_head_b),
    .axle_ba(ext_ba),
    .axle_ab(ext_ab)
  );

  ////////////////////////////////////////////////////////////////////////////
  // counting and occupancy

  // a sensor shared with the next section feeds both instances, so one
  // axle leaves here and enters there in the same cycle
  always_comb begin
    in_ent = s_q.ctrl[CTRL_ENTRY_BA] ? ent_ba : ent_ab;
    out_ent = s_q.ctrl[CTRL_ENTRY_BA] ? ent_ab : ent_ba;
    in_ext = s_q.ctrl[CTRL_EXIT_BA] ? ext_ba : ext_ab;
    out_ext = s_q.ctrl[CTRL_EXIT_BA] ? ext_ab : ext_ba;
    any_evt = in_ent | out_ent | in_ext | out_ext;
    n_in = (CNT_W+1)'(in_ent) + (CNT_W+1)'(in_ext);
    n_out = (CNT_W+1)'(out_ent) + (CNT_W+1)'(out_ext);
    sum_v = {1'b0, s_q.cnt} + n_in;
    res_v = '0;
    err_set = 1'b0;
    if (sum_v < n_out) begin
      err_set = 1'b1;
    end else if (sum_v - n_out > CNT_MAX) begin
      res_v = CNT_MAX;
      err_set = 1'b1;
    end else begin
      res_v = sum_v - n_out;
    end
  end

  // every redundant pair must agree and point the same way
  assign agree = (s_q.busy_a == s_q.busy_b) && (s_q.vac_a == s_q.vac_b) &&
                 (s_q.busy_a != s_q.vac_a) && (s_q.hrel_a == s_q.hrel_b) &&
                 (s_q.brel_a == s_q.brel_b) && (s_q.amp_a == s_q.amp_b);

  always_comb begin
    s_d = s_q;
    s_d.cnt = res_v[CNT_W-1:0];
    // a new fault beats a clear written in the same cycle
    if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_FAULT_CLR]) s_d.fault = 1'b0;
    if (err_set) s_d.fault = 1'b1;
    unique case (s_q.occ)
      OCC_CLEAR: begin
        if (any_evt) s_d.occ = OCC_BUSY;
      end
      OCC_BUSY: begin
        // restore only from a settled zero count with no fault pending
        if (!any_evt && s_q.cnt == '0 && !s_q.fault) s_d.occ = OCC_CLEAR;
      end
    endcase
    if (any_evt) s_d.occ = OCC_BUSY;

    // all outputs come from the one occupancy state
    s_d.amp_a = (s_d.occ == OCC_CLEAR);
    s_d.amp_b = (s_d.occ == OCC_CLEAR);
    s_d.busy_a = (s_d.occ == OCC_BUSY);
    s_d.busy_b = (s_d.occ == OCC_BUSY);
    s_d.vac_a = (s_d.occ == OCC_CLEAR);
    s_d.vac_b = (s_d.occ == OCC_CLEAR);

    ////////////////////////////////////////////////////////////////////////
    // relay chain, one relay stage per cycle

    s_d.hrel_a = s_q.amp_a;
    s_d.hrel_b = s_q.amp_b;
    s_d.brel_a = s_q.busy_a;
    s_d.brel_b = s_q.busy_b;
    s_d.summing = !s_q.brel_a && !s_q.brel_b;
    // busy relays dropping out open the short window for pick-up
    if ((s_q.brel_a || s_q.brel_b) && !s_q.busy_a && !s_q.busy_b) begin
      s_d.hold = HOLD_LOAD;
    end else if (s_q.hold != '0) begin
      s_d.hold = s_q.hold - HW'(1);
    end
    // vacancy picks up only inside the hold window, then holds itself
    s_d.vacancy = s_q.hrel_a && s_q.hrel_b && s_q.vac_a && s_q.vac_b &&
                  (s_q.vacancy || s_q.hold != '0);
    s_d.antival = (!s_q.hrel_a && !s_q.hrel_b) || !s_q.vacancy;
    s_d.line = s_q.vacancy && !s_q.antival && s_q.summing && agree &&
               s_q.occ == OCC_CLEAR;

    ////////////////////////////////////////////////////////////////////////
    // register port

    s_d.rdata = '0;
    if (reg_wr && reg_addr == REG_CTRL) s_d.ctrl = reg_wdata[CTRL_W-1:0];
    if (reg_rd) begin
      if (reg_addr == REG_CTRL) begin
        s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
      end else if (reg_addr == REG_STATUS) begin
        s_d.rdata[STAT_OCC] = (s_q.occ == OCC_BUSY);
        s_d.rdata[STAT_FAULT] = s_q.fault;
        s_d.rdata[STAT_CLEAR_LINE] = s_q.line;
        s_d.rdata[STAT_VACANCY] = s_q.vacancy;
        s_d.rdata[STAT_ANTIVALENT] = s_q.antival;
        s_d.rdata[STAT_SUMMING] = s_q.summing;
      end else if (reg_addr == REG_COUNT) begin
        s_d.rdata[CNT_W-1:0] = s_q.cnt;
      end
    end
  end

  // reset lands in the standby position with the clear line closed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{ctrl: CTRL_RESET, rdata: '0, occ: OCC_CLEAR, cnt: '0, fault: 1'b0,
               amp_a: 1'b1, amp_b: 1'b1, hrel_a: 1'b1, hrel_b: 1'b1,
               busy_a: 1'b0, busy_b: 1'b0, vac_a: 1'b1, vac_b: 1'b1,
               vacancy: 1'b1, antival: 1'b0, brel_a: 1'b0, brel_b: 1'b0,
               summing: 1'b1, hold: '0, line: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign amplifier_release_out_a = s_q.amp_a;
  assign amplifier_release_out_b = s_q.amp_b;
  assign head_release_relay_a = s_q.hrel_a;
  assign head_release_relay_b = s_q.hrel_b;
  assign busy_out_a = s_q.busy_a;
  assign busy_out_b = s_q.busy_b;
  assign vacant_out_a = s_q.vac_a;
  assign vacant_out_b = s_q.vac_b;
  assign vacancy_relay = s_q.vacancy;
  assign antivalent_relay = s_q.antival;
  assign busy_relay_a = s_q.brel_a;
  assign busy_relay_b = s_q.brel_b;
  assign busy_summing_relay = s_q.summing;
  assign clear_line = s_q.line;
  assign axle_count = s_q.cnt;
  assign count_fault = s_q.fault;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_amp_release_drop: assert property ($rose(s_q.busy_a) |-> !s_q.amp_a && !s_q.amp_b ##1
    !s_q.hrel_a && !s_q.hrel_b)
    else $error("release outputs did not drop with the first axle");
  chk_head_cuts_vac: assert property (!s_q.hrel_a || !s_q.hrel_b |=> !s_q.vacancy)
    else $error("vacancy relay held with a head relay released");
  chk_vac_opens_line: assert property (!s_q.vacancy |=> !s_q.line)
    else $error("clear line closed with vacancy relay dropped");
  chk_antival_on: assert property (!s_q.hrel_a && !s_q.hrel_b |=> s_q.antival ##1 !s_q.line)
    else $error("antivalent path did not break the line");
  chk_first_axle: assert property (any_evt |=> s_q.busy_a && s_q.busy_b &&
    !s_q.vac_a && !s_q.vac_b ##1 s_q.brel_a && s_q.brel_b)
    else $error("axle did not occupy the section");
  chk_summing_drop: assert property (s_q.brel_a |=> !s_q.summing ##1 !s_q.line)
    else $error("summing relay did not release");
  chk_in_out_both: assert property (n_in == n_out && !err_set |=> $stable(s_q.cnt))
    else $error("simultaneous in and out not balanced");
  chk_count_step: assert property (n_in == 1 && n_out == 0 && s_q.cnt != CNT_MAX[CNT_W-1:0]
    |=> s_q.cnt == $past(s_q.cnt) + CNT_W'(1))
    else $error("entry axle did not add one");
  chk_hold_inside: assert property (s_q.occ == OCC_BUSY && s_q.cnt != '0 |=> s_q.busy_a)
    else $error("section restored with axles inside");
  chk_restore_seq: assert property (s_q.occ == OCC_BUSY && s_q.cnt == '0 && !s_q.fault &&
    !any_evt |=> !s_q.busy_a && s_q.vac_a ##4 s_q.line)
    else $error("zero count did not restore the clear line");
  chk_underflow: assert property (s_q.cnt == '0 && n_out > n_in |=> s_q.fault &&
    s_q.busy_a && s_q.cnt == '0)
    else $error("count out at zero not flagged");
  chk_disagree: assert property (!agree |=> !s_q.line)
    else $error("clear line closed on disagreeing paths");

  cov_occupy: cover property ($rose(s_q.busy_a));
  cov_restore: cover property ($rose(s_q.line));
  cov_both_ways: cover property (n_in != '0 && n_out != '0);
  cov_fault: cover property ($rose(s_q.fault));

endmodule : acso_section

// ===== tb/acso_wheel_sensor.sv
// behavioural double wheel sensor driving two head levels
`timescale 1ns/1ps
module acso_wheel_sensor (
  input wire logic ref_clk,
  output logic head_a,
  output logic head_b
);
  initial begin
    head_a = 1'b0;
    head_b = 1'b0;
  end
  //////////////////////////////////////////////////////////////////
  task automatic step(input logic a, input logic b, input int n);
    @(posedge ref_clk);
    head_a <= a;
    head_b <= b;
    repeat (n - 1) @(posedge ref_clk);
  endtask : step
  // full flange crossing, first head, both, second head, clear
  task automatic pass(input logic b_first, input int ph);
    step(!b_first, b_first, ph);
    step(1'b1, 1'b1, ph);
    step(b_first, !b_first, ph);
    step(1'b0, 1'b0, ph + 12);
  endtask : pass
  // flange backs off after reaching both heads, so no axle
  task automatic rock(input int ph);
    step(1'b0, 1'b1, ph);
    step(1'b1, 1'b1, ph);
    step(1'b0, 1'b1, ph);
    step(1'b0, 1'b0, ph + 12);
  endtask : rock
  // too short for a flange
  task automatic glitch(input int n);
    step(1'b0, 1'b1, n);
    step(1'b0, 1'b0, 16);
  endtask : glitch
endmodule : acso_wheel_sensor

// ===== tb/acso_section_tb.sv
// self-checking bench for the section occupancy block
`timescale 1ns/1ps
module acso_section_tb;
  import acso_pkg::*;
  localparam logic [13:0] STANDBY = 14'h3CE3;
  localparam logic [13:0] OCCUPIED = 14'h031C;
  logic ref_clk = 1'b0;
  logic rd_d = 1'b0;
  logic nrst, reg_wr, reg_rd;
  logic [1:0] dir_cfg;
  logic [BUS_AW-1:0] reg_addr;
  logic [BUS_DW-1:0] reg_wdata, reg_rdata;
  logic en_a, en_b, ex_a, ex_b;
  logic amp_a, amp_b, hr_a, hr_b, bo_a, bo_b, vo_a, vo_b;
  logic vac, anti, br_a, br_b, sum, clear_line, count_fault;
  logic [7:0] axle_count;
  logic [7:0] cnt_last = 8'h00;
  logic [13:0] outs;
  logic [15:0] rd_q[$];
  logic [15:0] cnt_q[$];
  int fails, n_checks, n, i;
  integer seed;
  assign outs = {amp_a, amp_b, hr_a, hr_b, bo_a, bo_b, vo_a, vo_b, vac, anti, br_a, br_b,
                 sum, clear_line};
  always #25 ref_clk = ~ref_clk;
  //////////////////////////////////////////////////////////////////
  // short filter and hold keep the run brief
  acso_section #(.CNT_W(8), .FLT_CYC(4), .HOLD_CYC(8)) u_acso_section (
    .ref_clk(ref_clk), .nrst(nrst),
    .entry_head_a(en_a), .entry_head_b(en_b), .exit_head_a(ex_a), .exit_head_b(ex_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .amplifier_release_out_a(amp_a), .amplifier_release_out_b(amp_b),
    .head_release_relay_a(hr_a), .head_release_relay_b(hr_b),
    .busy_out_a(bo_a), .busy_out_b(bo_b), .vacant_out_a(vo_a), .vacant_out_b(vo_b),
    .vacancy_relay(vac), .antivalent_relay(anti), .busy_relay_a(br_a),
    .busy_relay_b(br_b), .busy_summing_relay(sum), .clear_line(clear_line),
    .axle_count(axle_count), .count_fault(count_fault));
  acso_wheel_sensor u_acso_wheel_sensor_en (.ref_clk(ref_clk), .head_a(en_a), .head_b(en_b));
  acso_wheel_sensor u_acso_wheel_sensor_ex (.ref_clk(ref_clk), .head_a(ex_a), .head_b(ex_b));
  //////////////////////////////////////////////////////////////////
  task automatic report(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask : report
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    report(got, exp);
  endtask : cmp_val
  task automatic cmp_out(input logic [13:0] got, input logic [13:0] exp);
    report({2'h0, got}, {2'h0, exp});
  endtask : cmp_out
  // relay chain settles over several stages, so poll with a bound
  task automatic wait_out(input logic [13:0] exp);
    int k;
    for (k = 0; k < 40 && outs !== exp; k++) @(negedge ref_clk);
    cmp_out(outs, exp);
  endtask : wait_out
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(exp);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    rd_d <= reg_rd;
    if (rd_d) cmp_val(reg_rdata, rd_q.pop_front());
  end
  // any count change with no note pending is a miscount
  always @(posedge ref_clk) begin
    if (nrst && axle_count !== cnt_last) begin
      if (cnt_q.size() == 0) cmp_val(16'(axle_count), 16'hFFFF);
      else cmp_val(16'(axle_count), cnt_q.pop_front());
    end
    cnt_last = axle_count;
  end
  initial begin
    #3_000_000;
    fails++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fails = 0;
    n_checks = 0;
    seed = 24189;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(REG_CTRL, 16'(CTRL_RESET));
    rd(REG_STATUS, 16'h002C);
    rd(8'h0C + 8'(($random(seed) & 3) * 4), 16'h0000);
    wait_out(STANDBY);
    $display("test reset done");
    u_acso_wheel_sensor_en.glitch(2 + ($random(seed) & 1));
    u_acso_wheel_sensor_en.rock(8);
    rd(REG_COUNT, 16'h0000);
    wait_out(STANDBY);
    $display("test filter done");
    n = ($random(seed) & 3) + 1;
    for (i = 1; i <= n; i++) begin
      cnt_q.push_back(16'(i));
      u_acso_wheel_sensor_en.pass(1'b1, 8);
      if (i == 1) wait_out(OCCUPIED);
    end
    rd(REG_STATUS, 16'h0011);
    $display("test entry done");
    fork
      u_acso_wheel_sensor_en.pass(1'b1, 8);
      u_acso_wheel_sensor_ex.pass(1'b1, 8);
    join
    rd(REG_COUNT, 16'(n));
    $display("test both sensors done");
    for (i = n - 1; i >= 0; i--) begin
      wait_out(OCCUPIED);
      cnt_q.push_back(16'(i));
      u_acso_wheel_sensor_ex.pass(1'b1, 8);
    end
    wait_out(STANDBY);
    $display("test exit done");
    u_acso_wheel_sensor_ex.pass(1'b1, 8);
    wait_out(OCCUPIED);
    cmp_val(16'(count_fault), 16'h0001);
    rd(REG_STATUS, 16'h0013);
    wr(REG_CTRL, 16'h0005);
    wait_out(STANDBY);
    cmp_val(16'(count_fault), 16'h0000);
    rd(REG_STATUS, 16'h002C);
    $display("test fault done");
    wr(8'h10 + 8'(($random(seed) & 7) * 32), 16'($random(seed)));
    dir_cfg = 2'($random(seed));
    wr(REG_CTRL, 16'(dir_cfg));
    rd(REG_CTRL, 16'(dir_cfg));
    cnt_q.push_back(16'h0001);
    u_acso_wheel_sensor_en.pass(dir_cfg[0], 8);
    cnt_q.push_back(16'h0000);
    u_acso_wheel_sensor_en.pass(!dir_cfg[0], 8);
    cnt_q.push_back(16'h0001);
    u_acso_wheel_sensor_ex.pass(dir_cfg[1], 8);
    wait_out(OCCUPIED);
    cnt_q.push_back(16'h0000);
    u_acso_wheel_sensor_ex.pass(!dir_cfg[1], 8);
    wait_out(STANDBY);
    cmp_val(16'(cnt_q.size()), 16'h0000);
    $display("test direction done");
    // reset in mid run must drop an occupied section back to standby
    cnt_q.push_back(16'h0001);
    u_acso_wheel_sensor_en.pass(dir_cfg[0], 8);
    wait_out(OCCUPIED);
    @(posedge ref_clk);
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    rd(REG_CTRL, 16'(CTRL_RESET));
    rd(REG_COUNT, 16'h0000);
    wait_out(STANDBY);
    cmp_val(16'(cnt_q.size()), 16'h0000);
    $display("test reset in run done");
    end_sim();
  end
endmodule : acso_section_tb
